// >>> design/efc_defs.vh
// constants for the evaporator fan control block
`ifndef EFC_DEFS_VH
`define EFC_DEFS_VH
// time base
`define EFC_CLK_HZ 10000000
`define EFC_TICK_MS 1000
`define EFC_TICK_CYCLES ((`EFC_CLK_HZ / 1000) * `EFC_TICK_MS)
// register byte offsets
`define EFC_OFS_CTRL 6'h00
`define EFC_OFS_MODE 6'h04
`define EFC_OFS_RESTART 6'h08
`define EFC_OFS_CUTOFF 6'h0C
`define EFC_OFS_THERMAL 6'h10
`define EFC_OFS_FANDLY 6'h14
`define EFC_OFS_BLIND 6'h18
`define EFC_OFS_STATUS 6'h1C
// control register fields
`define EFC_CTRL_ADV 0
`define EFC_CTRL_VAR_LO 1
`define EFC_CTRL_VAR_HI 2
`define EFC_CTRL_TWOZONE 3
`define EFC_CTRL_SENS2 4
`define EFC_CTRL_HEATCIRC 5
`define EFC_CTRL_OVRDIS 6
`define EFC_CTRL_RST 7'h00
// threshold registers: value in [15:0], disable or enable flag in bit 16
`define EFC_THR_FLAG 16
`define EFC_RESTART_RST 17'h00000
`define EFC_CUTOFF_RST 17'h00000
`define EFC_THERMAL_RST 17'h00000
// mode register: normal setpoint [1:0], alternative setpoint [3:2]
`define EFC_MODE_RST 4'h0
`define EFC_MODE_CONT 2'h0
`define EFC_MODE_DELAY 2'h1
`define EFC_MODE_OVR 2'h2
`define EFC_MODE_FORE 2'h3
// controller variants
`define EFC_VAR_CASE 2'h0
`define EFC_VAR_ZONE 2'h1
`define EFC_VAR_HEAT 2'h2
`define EFC_VAR_COLD 2'h3
`endif

// >>> design/efc_tick_gen.v
// divider producing the one-cycle control tick enable
`timescale 1ns/1ps
`default_nettype none
module efc_tick_gen #(
  parameter DIV = 10000000
) (
  input wire clk,
  input wire rst,
  output reg tick
);
  reg [31:0] cnt_r;

  // tick fires once every DIV cycles
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 32'h0;
      tick <= 1'b0;
    end
    else if (cnt_r >= DIV - 1)
    begin
      cnt_r <= 32'h0;
      tick <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> design/efc_delay_timer.v
// down counter in control ticks, busy while counting
`timescale 1ns/1ps
`default_nettype none
module efc_delay_timer #(
  parameter W = 16
) (
  input wire clk,
  input wire rst,
  input wire tick,
  input wire load,
  input wire [W-1:0] loadVal,
  output wire busy
);
  reg [W-1:0] cnt_r;

  // load wins over counting so a restart is never lost
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_r <= {W{1'b0}};
    else if (load)
      cnt_r <= loadVal;
    else if (tick && cnt_r != {W{1'b0}})
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
  end

  assign busy = (cnt_r != {W{1'b0}});
endmodule
`default_nettype wire

// >>> design/efc_fan_ctrl.v
// evaporator fan control core with avalon-mm register slave
// Notes on behaviour
// - advanced case mode drives relay inverted
// - advanced mode routes alarms to dc output
// - four fan modes, per setpoint selection
// - continuous mode: fan always on
// - delay mode: off in defrost, restart below
// - restart uses sensor one, both if two-zone with sensor two set
// - delay mode: off during wait and drip
// - overrun: stop above cutoff, restart below
// - overrun/forerun: hold in drip, cutoff in wait
// - overrun/forerun sensor choice as restart
// - forerun: off, on above cutoff, on after
// - zone variant: blind stop on toggle one-to-two
// - thermal delay withholds restart after defrost
// - coldroom zones run independently
// - heated coldroom: fan follows cooling
// - fan pre-run before cooling when delay set
// - heated coldroom: fan off defrost, holds its state in wait
// - unheated coldroom: overrun after cooling stops
// - overrun stop needs time and temperature
// - heating circuit: fan one follows heater
// - coldroom variants drive relay normally open
// - delay mode: restart disabled keeps fan running always
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "efc_defs.vh"
module efc_fan_ctrl #(
  parameter TICK_CYCLES = `EFC_TICK_CYCLES,
  parameter TW = 16
) (
  input wire clk,
  input wire rst,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire signed [15:0] firstEvapTemp,
  input wire signed [15:0] secondEvapTemp,
  input wire coolingActive,
  input wire defrostActive,
  input wire waitPeriod,
  input wire dripPeriod,
  input wire [1:0] coolDemand,
  input wire altSetpoint,
  input wire heaterRelay,
  input wire alarmReq,
  output reg [1:0] fanContact,
  output reg [1:0] coolPermit,
  output reg alarmMainsRelay,
  output reg alarmDcOut
);
  reg [6:0] ctrl_r;
  reg [3:0] mode_r;
  reg [16:0] restart_r;
  reg [16:0] cutoff_r;
  reg [16:0] thermal_r;
  reg [TW-1:0] fanDly_r;
  reg [TW-1:0] blindTime_r;
  reg ack_r;
  reg altPrev_r;
  reg heatPrev_r;
  reg hotStop_r;
  reg [1:0] fan_r;
  reg [1:0] hold_r;
  wire tick;
  wire blindBusy;
  wire [1:0] dlyBusy;
  wire [1:0] dlyLoad;
  wire [1:0] variant;
  wire [1:0] fanMode;
  wire caseVar;
  wire use2;
  wire restartDis;
  wire thermEn;
  wire ovrEn;
  wire [1:0] below;
  wire [1:0] above;
  wire [1:0] warm;
  wire belowBoth;
  wire aboveBoth;
  wire blindLoad;
  wire [1:0] fanEff;
  wire [31:0] wrWord;
  reg [31:0] curWord;

  // byte-lane merge for register writes
  function [31:0] laneMerge;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0] be;
    integer k;
    begin
      laneMerge = oldVal;
      for (k = 0; k < 4; k = k + 1)
        if (be[k])
          laneMerge[8*k +: 8] = newVal[8*k +: 8];
    end
  endfunction

  efc_tick_gen #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .tick(tick)
  );

  // configuration decode
  assign variant = ctrl_r[`EFC_CTRL_VAR_HI:`EFC_CTRL_VAR_LO];
  assign caseVar = (variant == `EFC_VAR_CASE) || (variant == `EFC_VAR_ZONE);
  assign fanMode = altSetpoint ? mode_r[3:2] : mode_r[1:0];
  assign restartDis = restart_r[`EFC_THR_FLAG];
  assign thermEn = thermal_r[`EFC_THR_FLAG];
  assign ovrEn = (fanDly_r != {TW{1'b0}}) && !ctrl_r[`EFC_CTRL_OVRDIS];
  assign use2 = ctrl_r[`EFC_CTRL_TWOZONE] && ctrl_r[`EFC_CTRL_SENS2];

  // sensor comparisons against the thresholds
  assign below[0] = firstEvapTemp < $signed(restart_r[15:0]);
  assign below[1] = secondEvapTemp < $signed(restart_r[15:0]);
  assign above[0] = firstEvapTemp > $signed(cutoff_r[15:0]);
  assign above[1] = secondEvapTemp > $signed(cutoff_r[15:0]);
  assign warm[0] = firstEvapTemp >= $signed(thermal_r[15:0]);
  assign warm[1] = secondEvapTemp >= $signed(thermal_r[15:0]);

  // case controllers combine sensors; second ignored when absent
  assign belowBoth = below[0] && (!use2 || below[1]);
  assign aboveBoth = above[0] && (!use2 || above[1]);

  // night blind stop only on the one-to-two setpoint edge
  assign blindLoad = tick && altSetpoint && !altPrev_r
    && (variant == `EFC_VAR_ZONE);

  efc_delay_timer #(
    .W(TW)
  ) u_blind (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .load(blindLoad),
    .loadVal(blindTime_r),
    .busy(blindBusy)
  );

  // per-zone fan state; each coldroom zone has its own sensor and relay
  genvar z;
  generate
    for (z = 0; z < 2; z = z + 1)
    begin : g_zone
      reg coolPrev_r;
      reg demPrev_r;
      reg defPrev_r;
      reg phPrev_r;
      reg prerun_r;
      wire zBelow;
      wire zAbove;
      wire zWarm;
      wire zActive;
      wire phase;

      assign zBelow = caseVar ? belowBoth : below[z];
      assign zAbove = caseVar ? aboveBoth : above[z];
      assign zWarm = warm[z];
      // zone two exists only in coldroom two-zone operation
      assign zActive = (z == 0) ||
        (!caseVar && ctrl_r[`EFC_CTRL_TWOZONE]);
      // overrun and forerun treat the wait time as part of defrost
      assign phase = defrostActive || waitPeriod;

      // pre-run load on demand rise, overrun load on cooling fall
      assign dlyLoad[z] = tick && (
        ((variant == `EFC_VAR_HEAT) && coolDemand[z] && !demPrev_r
          && (fanDly_r != {TW{1'b0}})) ||
        ((variant == `EFC_VAR_COLD) && !coolingActive && coolPrev_r && ovrEn));

      efc_delay_timer #(
        .W(TW)
      ) u_dly (
        .clk(clk),
        .rst(rst),
        .tick(tick),
        .load(dlyLoad[z]),
        .loadVal(fanDly_r),
        .busy(dlyBusy[z])
      );

      // fan decision, evaluated once per control tick
      always @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          fan_r[z] <= 1'b0;
          hold_r[z] <= 1'b0;
          coolPrev_r <= 1'b0;
          demPrev_r <= 1'b0;
          defPrev_r <= 1'b0;
          phPrev_r <= 1'b0;
          prerun_r <= 1'b0;
        end
        else if (tick)
        begin
          coolPrev_r <= coolingActive;
          demPrev_r <= coolDemand[z];
          defPrev_r <= defrostActive;
          phPrev_r <= phase;
          if (!zActive)
          begin
            fan_r[z] <= 1'b0;
            hold_r[z] <= 1'b0;
          end
          else
          begin
            case (variant)
              `EFC_VAR_CASE:
              begin
                case (fanMode)
                  `EFC_MODE_CONT:
                  begin
                    fan_r[z] <= 1'b1;
                    hold_r[z] <= 1'b0;
                  end
                  `EFC_MODE_DELAY:
                  begin
                    if (restartDis)
                    begin
                      fan_r[z] <= 1'b1;
                      hold_r[z] <= 1'b0;
                    end
                    else if (defrostActive || waitPeriod || dripPeriod)
                    begin
                      fan_r[z] <= 1'b0;
                      hold_r[z] <= 1'b1;
                    end
                    else if (hold_r[z])
                    begin
                      // cutoff threshold plays no part here
                      if (zBelow)
                      begin
                        fan_r[z] <= 1'b1;
                        hold_r[z] <= 1'b0;
                      end
                    end
                    else
                      fan_r[z] <= 1'b1;
                  end
                  `EFC_MODE_OVR:
                  begin
                    if (dripPeriod)
                      fan_r[z] <= fan_r[z];
                    else if (phase)
                    begin
                      if (zAbove)
                      begin
                        fan_r[z] <= 1'b0;
                        hold_r[z] <= 1'b1;
                      end
                    end
                    else if (hold_r[z])
                    begin
                      if (zBelow)
                      begin
                        fan_r[z] <= 1'b1;
                        hold_r[z] <= 1'b0;
                      end
                    end
                    else
                      fan_r[z] <= 1'b1;
                  end
                  default:
                  begin
                    // forerun: restart threshold is not consulted
                    hold_r[z] <= 1'b0;
                    if (dripPeriod)
                      fan_r[z] <= fan_r[z];
                    else if (phase && !phPrev_r)
                      fan_r[z] <= 1'b0;
                    else if (phase)
                    begin
                      if (zAbove)
                        fan_r[z] <= 1'b1;
                    end
                    else
                      fan_r[z] <= 1'b1;
                  end
                endcase
              end
              `EFC_VAR_ZONE:
              begin
                if (defrostActive)
                begin
                  fan_r[z] <= 1'b0;
                  hold_r[z] <= thermEn;
                end
                else if (hold_r[z])
                begin
                  // keep heat out of the case until the coil is cold
                  if (!zWarm)
                  begin
                    fan_r[z] <= 1'b1;
                    hold_r[z] <= 1'b0;
                  end
                end
                else
                  fan_r[z] <= 1'b1;
              end
              `EFC_VAR_HEAT:
              begin
                if (dlyLoad[z])
                  prerun_r <= 1'b1;
                else if (!dlyBusy[z])
                  prerun_r <= 1'b0;
                if (defrostActive)
                begin
                  fan_r[z] <= 1'b0;
                  hold_r[z] <= thermEn;
                end
                else if (waitPeriod)
                  fan_r[z] <= fan_r[z];
                else if (hold_r[z])
                begin
                  if (!zWarm)
                  begin
                    fan_r[z] <= 1'b1;
                    hold_r[z] <= 1'b0;
                  end
                end
                else
                  fan_r[z] <= coolingActive || dlyLoad[z] || prerun_r;
              end
              default:
              begin
                hold_r[z] <= 1'b0;
                if (!ovrEn || coolingActive || defrostActive)
                  fan_r[z] <= 1'b1;
                else if (!dlyBusy[z] && !dlyLoad[z] && zWarm)
                  fan_r[z] <= 1'b0;
              end
            endcase
          end
        end
      end

      // cooling starts only after the pre-run, if demand still stands
      always @(posedge clk or posedge rst)
      begin
        if (rst)
          coolPermit[z] <= 1'b0;
        else if (variant == `EFC_VAR_HEAT)
          coolPermit[z] <= coolDemand[z] && zActive && !dlyBusy[z]
            && !dlyLoad[z] && !prerun_r;
        else
          coolPermit[z] <= coolDemand[z] && zActive;
      end
    end
  endgenerate

  // heating circuit: zone one fan follows the heater relay
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      heatPrev_r <= 1'b0;
      hotStop_r <= 1'b0;
      altPrev_r <= 1'b0;
    end
    else if (tick)
    begin
      heatPrev_r <= heaterRelay;
      altPrev_r <= altSetpoint;
      if (!heaterRelay && heatPrev_r && above[0])
        hotStop_r <= 1'b1;
      else if (heaterRelay || (coolingActive && !g_zone[0].coolPrev_r))
        hotStop_r <= 1'b0;
    end
  end

  assign fanEff[0] = (!caseVar && ctrl_r[`EFC_CTRL_HEATCIRC])
    ? (heaterRelay || (fan_r[0] && !hotStop_r))
    : (fan_r[0] && !(blindBusy && variant == `EFC_VAR_ZONE));
  assign fanEff[1] = fan_r[1];

  // relay contacts: case variants open to run, coldroom closes to run
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fanContact <= 2'h0;
      alarmMainsRelay <= 1'b0;
      alarmDcOut <= 1'b0;
    end
    else
    begin
      if (caseVar)
        fanContact <= ~fanEff;
      else
        fanContact <= fanEff;
      // mains alarm relay is taken by the fan in advanced mode
      alarmMainsRelay <= alarmReq && !(ctrl_r[`EFC_CTRL_ADV] && caseVar);
      alarmDcOut <= alarmReq && ctrl_r[`EFC_CTRL_ADV] && caseVar;
    end
  end

  // one wait state: data is prepared first, the access completes next
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

  // readback word, also the base that a write merges its lanes into
  always @*
  begin
    case (avs_address)
      `EFC_OFS_CTRL: curWord = {25'h0, ctrl_r};
      `EFC_OFS_MODE: curWord = {28'h0, mode_r};
      `EFC_OFS_RESTART: curWord = {15'h0, restart_r};
      `EFC_OFS_CUTOFF: curWord = {15'h0, cutoff_r};
      `EFC_OFS_THERMAL: curWord = {15'h0, thermal_r};
      `EFC_OFS_FANDLY: curWord = {{(32-TW){1'b0}}, fanDly_r};
      `EFC_OFS_BLIND: curWord = {{(32-TW){1'b0}}, blindTime_r};
      `EFC_OFS_STATUS: curWord = {21'h0, blindBusy, dlyBusy, hold_r, coolPermit, fanContact,
        fan_r};
      default: curWord = 32'h0;
    endcase
  end

  // merged word is cut to each register's width on purpose
  assign wrWord = laneMerge(curWord, avs_writedata, avs_byteenable);

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ack_r <= 1'b0;
      avs_readdata <= 32'h0;
      ctrl_r <= `EFC_CTRL_RST;
      mode_r <= `EFC_MODE_RST;
      restart_r <= `EFC_RESTART_RST;
      cutoff_r <= `EFC_CUTOFF_RST;
      thermal_r <= `EFC_THERMAL_RST;
      fanDly_r <= {TW{1'b0}};
      blindTime_r <= {TW{1'b0}};
    end
    else
    begin
      ack_r <= (avs_read || avs_write) && !ack_r;
      if (avs_read && !ack_r)
        avs_readdata <= curWord;
      // writes land on the edge where waitrequest is low
      if (avs_write && ack_r)
      begin
        case (avs_address)
          `EFC_OFS_CTRL: ctrl_r <= wrWord[6:0];
          `EFC_OFS_MODE: mode_r <= wrWord[3:0];
          `EFC_OFS_RESTART: restart_r <= wrWord[16:0];
          `EFC_OFS_CUTOFF: cutoff_r <= wrWord[16:0];
          `EFC_OFS_THERMAL: thermal_r <= wrWord[16:0];
          `EFC_OFS_FANDLY: fanDly_r <= wrWord[TW-1:0];
          `EFC_OFS_BLIND: blindTime_r <= wrWord[TW-1:0];
          default: ack_r <= 1'b0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/efc_evap_model.sv
// evaporator sensor pair and fan relay model for the fan control bench
`timescale 1ns/1ps
`default_nettype none
module efc_evap_model (
  input wire logic clk,
  input wire logic [15:0] setTemp1,
  input wire logic [15:0] setTemp2,
  input wire logic [1:0] fanContact,
  input wire logic normOpen,
  output logic signed [15:0] firstEvapTemp,
  output logic signed [15:0] secondEvapTemp,
  output logic [1:0] fanRunning
);
  // probes report one clock late, so the block never sees a same-edge change
  always @(posedge clk)
  begin
    firstEvapTemp <= setTemp1;
    secondEvapTemp <= setTemp2;
  end
  // an inverted relay runs the fan with its contact open
  assign fanRunning = normOpen ? fanContact : ~fanContact;
endmodule
`default_nettype wire

// >>> test/efc_fan_ctrl_assertions.sv
// assertion checker for the evaporator fan control block
`timescale 1ns/1ps
`default_nettype none
module efc_fan_ctrl_assertions (
  input wire clk,
  input wire rst,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire signed [15:0] firstEvapTemp,
  input wire signed [15:0] secondEvapTemp,
  input wire coolingActive,
  input wire defrostActive,
  input wire waitPeriod,
  input wire dripPeriod,
  input wire [1:0] coolDemand,
  input wire altSetpoint,
  input wire heaterRelay,
  input wire alarmReq,
  input wire [1:0] fanContact,
  input wire [1:0] coolPermit,
  input wire alarmMainsRelay,
  input wire alarmDcOut
);
  reg [6:0] ctrl_r;
  reg [3:0] mode_r;
  reg restOff_r;
  reg thermOn_r;
  // shadow of the fan steering registers; partial-lane writes are not tracked
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r <= 7'h00;
      mode_r <= 4'h0;
      restOff_r <= 1'b0;
      thermOn_r <= 1'b0;
    end
    else if (avs_write && !avs_waitrequest)
    begin
      if (avs_address == 6'h00)
        ctrl_r <= avs_writedata[6:0];
      if (avs_address == 6'h04)
        mode_r <= avs_writedata[3:0];
      if (avs_address == 6'h08)
        restOff_r <= avs_writedata[16];
      if (avs_address == 6'h10)
        thermOn_r <= avs_writedata[16];
    end
  end
  // decoded operating situation
  wire [1:0] selMode = altSetpoint ? mode_r[3:2] : mode_r[1:0];
  wire advCase = ctrl_r[0] && ctrl_r[2:1] == 2'h0;
  wire contAdv = advCase && selMode == 2'h0;
  wire delayAdv = advCase && selMode == 2'h1 && !restOff_r;
  wire heatRoom = ctrl_r[2:1] == 2'h2;
  wire rdDone = avs_read && !avs_waitrequest;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  a_stall_first:
    assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("request not stalled on its first cycle");
  a_one_wait:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request stalled beyond one cycle");
  a_idle_ready:
    assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("stall raised with no request");
  a_unmapped_zero:
    assert property (rdDone && (avs_address[1:0] != 2'h0 || avs_address > 6'h1C)
      |-> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_ctrl_width:
    assert property (rdDone && avs_address == 6'h00 |-> avs_readdata[31:7] == 25'h0000000)
    else $error("control read shows bits above its width");
  a_cont_inverted:
    assert property (contAdv [*8] |-> fanContact[0] == 1'b0)
    else $error("continuous fan not running through open contact");
  a_delay_defrost:
    assert property ((delayAdv && defrostActive) [*8] |-> fanContact[0] == 1'b1)
    else $error("fan runs during defrost in delay mode");
  a_alarm_dc:
    assert property ((ctrl_r[0] && !ctrl_r[2] && alarmReq) [*8] |-> alarmDcOut && !alarmMainsRelay)
    else $error("alarm not moved to the dc output");
  a_heat_run:
    assert property ((heatRoom && coolingActive && !defrostActive && !waitPeriod && !thermOn_r) [*8]
      |-> fanContact[0])
    else $error("coldroom fan contact open while cooling");
  a_heat_defrost:
    assert property ((heatRoom && defrostActive) [*8] |-> !fanContact[0])
    else $error("coldroom fan contact closed in defrost");
  c_cont_run: cover property (contAdv [*8]);
  c_delay_stop: cover property ((delayAdv && defrostActive) [*8]);
  c_heat_run: cover property ((heatRoom && coolingActive) [*8]);
endmodule
bind efc_fan_ctrl efc_fan_ctrl_assertions i_chk (.clk(clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .firstEvapTemp(firstEvapTemp), .secondEvapTemp(secondEvapTemp),
  .coolingActive(coolingActive), .defrostActive(defrostActive),
  .waitPeriod(waitPeriod), .dripPeriod(dripPeriod), .coolDemand(coolDemand),
  .altSetpoint(altSetpoint), .heaterRelay(heaterRelay), .alarmReq(alarmReq),
  .fanContact(fanContact), .coolPermit(coolPermit),
  .alarmMainsRelay(alarmMainsRelay), .alarmDcOut(alarmDcOut));
`default_nettype wire

// >>> test/evaporator_fan_control_test.sv
// self-checking bench for the evaporator fan control block
`timescale 1ns/1ps
`default_nettype none
module evaporator_fan_control_test;
  localparam int TK = 4;
  localparam logic [15:0] cold = 16'h0000, warm = 16'h000A, hot = 16'h001E;
  localparam logic [3:0] kCool = 4'h8, kDef = 4'h4, kWait = 4'h2, kDrip = 4'h1, kIdle = 4'h0;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h00000000;
  logic [3:0] seq = 4'h0;
  logic [15:0] t1 = 16'h0000;
  logic [15:0] t2 = 16'h0000;
  logic [1:0] demand = 2'h0;
  logic alt = 1'b0;
  logic heater = 1'b0;
  logic alarm = 1'b0;
  logic normOpen = 1'b0;
  wire [31:0] rdat;
  wire wreq;
  wire signed [15:0] e1;
  wire signed [15:0] e2;
  wire [1:0] contact;
  wire [1:0] permit;
  wire [1:0] run;
  wire alMains;
  wire alDc;
  int fails = 0;
  int samples_checked = 0;
  always #50 clk = ~clk;
  // short tick keeps every fan decision a few clocks apart
  efc_fan_ctrl #(.TICK_CYCLES(TK)) i_dut (.clk(clk), .rst(rst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hF),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .firstEvapTemp(e1),
    .secondEvapTemp(e2), .coolingActive(seq[3]), .defrostActive(seq[2]),
    .waitPeriod(seq[1]), .dripPeriod(seq[0]), .coolDemand(demand), .altSetpoint(alt),
    .heaterRelay(heater), .alarmReq(alarm), .fanContact(contact), .coolPermit(permit),
    .alarmMainsRelay(alMains), .alarmDcOut(alDc));
  efc_evap_model i_model (.clk(clk), .setTemp1(t1), .setTemp2(t2), .fanContact(contact),
    .normOpen(normOpen), .firstEvapTemp(e1), .secondEvapTemp(e2), .fanRunning(run));
  task automatic report_and_stop;
    if (fails == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one avalon transfer: hold everything until the stall drops at an edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    @(posedge clk);
    while (wreq)
      @(posedge clk);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    chk(q, e);
  endtask
  // apply a sequencer phase and probe temperatures, then judge the fan
  task automatic st(input logic [3:0] s, input logic [15:0] a, input logic [15:0] b,
    input logic e);
    seq <= s;
    t1 <= a;
    t2 <= b;
    repeat (4 * TK) @(posedge clk);
    chk({31'h0, run[0]}, {31'h0, e});
  endtask
  task automatic t_regs;
    for (int i = 0; i < 7; i++)
      rchk(6'(4 * i), 32'h00000000);
    wreg(6'h00, 32'hFFFFFFFF);
    rchk(6'h00, 32'h0000007F);
    wreg(6'h04, 32'hFFFFFFFF);
    rchk(6'h04, 32'h0000000F);
    wreg(6'h22, 32'h12345678);
    rchk(6'h22, 32'h00000000);
  endtask
  task automatic t_cont;
    wreg(6'h00, 32'h00000001);
    wreg(6'h04, 32'h00000000);
    st(kDef, hot, hot, 1'b1);
    chk({31'h0, contact[0]}, 32'h00000000);
    alarm <= 1'b1;
    repeat (3 * TK) @(posedge clk);
    chk({30'h0, alDc, alMains}, 32'h00000002);
    alarm <= 1'b0;
  endtask
  task automatic t_delay;
    wreg(6'h08, 32'h00000005);
    wreg(6'h0C, 32'h00000014);
    wreg(6'h04, 32'h00000001);
    st(kCool, cold, cold, 1'b1);
    st(kWait, cold, cold, 1'b0);
    st(kDef, hot, hot, 1'b0);
    st(kDrip, hot, hot, 1'b0);
    st(kCool, hot, hot, 1'b0);
    st(kCool, cold, hot, 1'b1);
    wreg(6'h00, 32'h00000019);
    st(kDef, hot, hot, 1'b0);
    st(kCool, cold, hot, 1'b0);
    st(kCool, cold, cold, 1'b1);
    wreg(6'h00, 32'h00000009);
    st(kDef, hot, hot, 1'b0);
    st(kCool, cold, hot, 1'b1);
    wreg(6'h08, 32'h00010005);
    st(kDef, hot, hot, 1'b1);
    wreg(6'h08, 32'h00000005);
  endtask
  task automatic t_alt;
    wreg(6'h04, 32'h00000004);
    alt <= 1'b1;
    st(kDef, hot, hot, 1'b0);
    alt <= 1'b0;
    st(kDef, hot, hot, 1'b1);
  endtask
  task automatic t_over;
    wreg(6'h00, 32'h00000001);
    wreg(6'h04, 32'h00000002);
    st(kCool, cold, cold, 1'b1);
    st(kWait, hot, hot, 1'b0);
    st(kCool, cold, cold, 1'b1);
    st(kDef, warm, warm, 1'b1);
    st(kDef, hot, hot, 1'b0);
    st(kDrip, warm, warm, 1'b0);
    st(kCool, warm, warm, 1'b0);
    st(kCool, cold, cold, 1'b1);
    wreg(6'h00, 32'h00000019);
    st(kDef, hot, cold, 1'b1);
    st(kDef, hot, hot, 1'b0);
    st(kCool, cold, cold, 1'b1);
  endtask
  task automatic t_fore;
    wreg(6'h00, 32'h00000001);
    wreg(6'h04, 32'h00000003);
    st(kCool, cold, cold, 1'b1);
    st(kWait, cold, cold, 1'b0);
    st(kDef, warm, warm, 1'b0);
    st(kDrip, hot, hot, 1'b0);
    st(kCool, warm, warm, 1'b1);
    st(kWait, hot, hot, 1'b1);
  endtask
  task automatic t_heat;
    wreg(6'h00, 32'h00000004);
    normOpen <= 1'b1;
    st(kCool, hot, hot, 1'b1);
    chk({30'h0, contact}, 32'h00000001);
    st(kIdle, hot, hot, 1'b0);
    alarm <= 1'b1;
    st(kDef, hot, hot, 1'b0);
    chk({30'h0, alDc, alMains}, 32'h00000001);
    alarm <= 1'b0;
    wreg(6'h14, 32'h00000014);
    demand <= 2'h1;
    st(kIdle, hot, hot, 1'b1);
    chk({31'h0, permit[0]}, 32'h00000000);
    repeat (24 * TK) @(posedge clk);
    chk({30'h0, permit}, 32'h00000001);
    demand <= 2'h0;
  endtask
  // zone-defrost case: blind stop on the setpoint edge, thermal hold after defrost
  task automatic t_zone;
    normOpen <= 1'b0;
    wreg(6'h00, 32'h00000002);
    wreg(6'h18, 32'h00000006);
    wreg(6'h10, 32'h00010014);
    st(kCool, cold, cold, 1'b1);
    alt <= 1'b1;
    st(kCool, cold, cold, 1'b0);
    alt <= 1'b0;
    st(kCool, cold, cold, 1'b1);
    st(kDef, hot, hot, 1'b0);
    st(kCool, hot, hot, 1'b0);
    st(kCool, cold, cold, 1'b1);
  endtask
  // reset, then every scenario in turn
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_cont();
    t_delay();
    t_alt();
    t_over();
    t_fore();
    t_heat();
    t_zone();
    report_and_stop();
  end
  // the whole run needs about a tenth of this span
  initial
  begin
    #1ms;
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
